// *** src/asx_pkg.sv ***
/*
 * Shared constants for the automatic serial transfer controller.
 * Assumes a 16-bit register address space with byte-wide registers.
 */
// Functional notes
// R1: Reset clears control and interval registers.
// R2: Control register takes bit and byte writes.
// R3: Control bit 7 enables storing received bytes.
// R4: Reception off keeps serial input as port.
// R5: Control bit 6 selects one-shot or repeat.
// R6: Shift register write sets busy bit 3.
// R7: Busy clears on suspend or one-shot end.
// R8: Busy bit ignores processor writes.
// R9: Software polls busy, not interrupt flag.
// R10: Interval bit 7 enables timed byte gap.
// R11: Value zero gives 2.5 serial periods.
// R12: Values 1-31 give n+1.5 serial periods.
// R13: Software never writes interval while running.
// R14: Software writes zero to interval bits 5-6.
// R15: Shift register write starts sequence, value discarded.
// R16: Pointer decrements per byte until zero sent.
// R17: Serial output low while busy is clear.
// R18: Gap timer counts serial clock half-periods.
package asx_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam logic [15:0] OFS_CTRL     = 16'hFF79;
	localparam logic [15:0] OFS_SHIFT    = 16'hFF7A;
	localparam logic [15:0] OFS_INTERVAL = 16'hFF7B;
	localparam logic [15:0] OFS_IRQ_STAT = 16'hFF7C;
	localparam logic [15:0] OFS_IRQ_CLR  = 16'hFF7D;
	localparam logic [15:0] OFS_IRQ_EN   = 16'hFF7E;
	localparam logic [15:0] OFS_POINTER  = 16'hFF7F;
	localparam int unsigned CTRL_RX_EN  = 7;
	localparam int unsigned CTRL_REPEAT = 6;
	localparam int unsigned CTRL_BUSY   = 3;
	localparam int unsigned INTV_CTRL   = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] INTV_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hC0;
	localparam logic [7:0] INTV_WMASK = 8'h9F;
	localparam logic [1:0] IRQ_RESET  = 2'h0;
	localparam int unsigned IRQ_END  = 0;
	localparam int unsigned IRQ_BYTE = 1;
	localparam int unsigned PTR_W = 4;
	localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
	localparam logic [6:0] GAP_N0_PERIODS = 7'h02;
	localparam logic [6:0] GAP_HALF_EXTRA = 7'h01;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	typedef enum logic [3:0] {
		ASX_IDLE  = 4'b0001,
		ASX_LOAD  = 4'b0010,
		ASX_SHIFT = 4'b0100,
		ASX_GAP   = 4'b1000
	} asx_state_t;
endpackage

// *** src/asx_shifter.sv ***
/*
 * Byte shifter on an externally supplied serial clock.
 * Assumes the serial clock and serial input are asynchronous pins.
 */
`timescale 1ns/100ps
`default_nettype none
module asx_shifter
	import asx_pkg::*;
(
	input  wire logic       i_ref_clk, // System clock.
	input  wire logic       i_srst,    // Synchronous reset, high.
	input  wire logic       i_sck,     // Serial clock pin.
	input  wire logic       i_si,      // Serial data pin.
	input  wire logic       i_start,   // Load and start one byte.
	input  wire logic [7:0] i_data,    // Byte to send.
	output logic            o_half,    // Pulse on each serial clock edge.
	output logic            o_done,    // Pulse after eighth rising edge.
	output logic [7:0]      o_data,    // Received byte.
	output logic            o_so       // Serial data out.
);
	logic [2:0] sck_s_q, si_s_q;
	logic       sck_lvl_q, si_lvl_q, run_q, arm_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic       rise, fall;

	// Three-stage synchronisers; a change counts once stages two and three agree.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			sck_s_q   <= 3'h7;
			si_s_q    <= 3'h0;
			sck_lvl_q <= 1'b1;
			si_lvl_q  <= 1'b0;
		end else begin
			sck_s_q <= {sck_s_q[1:0], i_sck};
			si_s_q  <= {si_s_q[1:0], i_si};
			if (sck_s_q[1] == sck_s_q[2]) sck_lvl_q <= sck_s_q[2];
			if (si_s_q[1] == si_s_q[2]) si_lvl_q <= si_s_q[2];
		end
	end

	// Edge pulses are formed from the filtered serial clock level.
	assign rise = (sck_s_q[1] == sck_s_q[2]) && sck_s_q[2] && !sck_lvl_q;
	assign fall = (sck_s_q[1] == sck_s_q[2]) && !sck_s_q[2] && sck_lvl_q;

	// Data leaves on the falling edge and is sampled on the rising edge.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			run_q  <= 1'b0;
			arm_q  <= 1'b0;
			cnt_q  <= 4'h0;
			sh_q   <= 8'h00;
			o_so   <= 1'b0;
			o_done <= 1'b0;
			o_half <= 1'b0;
		end else begin
			o_done <= 1'b0;
			o_half <= rise | fall; // [R18]
			// A frame opens with the fall that puts out the first bit, so an earlier rise is no bit.
			if (i_start) begin
				run_q <= 1'b1;
				arm_q <= 1'b0;
				cnt_q <= 4'h0;
				sh_q  <= i_data;
			end else if (run_q && fall) begin
				arm_q <= 1'b1;
				o_so  <= sh_q[7];
			end else if (run_q && arm_q && rise) begin
				sh_q  <= {sh_q[6:0], si_lvl_q};
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == BITS_PER_BYTE - 4'h1) begin
					run_q  <= 1'b0;
					o_done <= 1'b1;
				end
			end
		end
	end

	assign o_data = sh_q;
endmodule
`default_nettype wire

// *** src/asx_gap_timer.sv ***
/*
 * Inter-byte gap timer counting serial clock half-periods.
 * Assumes one half-period pulse per serial clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module asx_gap_timer
	import asx_pkg::*;
(
	input  wire logic       i_ref_clk, // System clock.
	input  wire logic       i_srst,    // Synchronous reset, high.
	input  wire logic       i_start,   // Begin a gap.
	input  wire logic       i_timed,   // Interval control enabled.
	input  wire logic [4:0] i_n,       // Interval value.
	input  wire logic       i_half,    // Half-period pulse.
	output logic            o_done     // Pulse at gap end.
);
	logic [6:0] left_q;
	logic       run_q;
	logic [6:0] periods;

	// Zero maps to two periods, otherwise n plus one periods.
	assign periods = (i_n == 5'h00) ? GAP_N0_PERIODS : {2'b00, i_n} + 7'h01; // [R11] [R12]

	// Counts down doubled periods plus one half-period.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			left_q <= 7'h00;
			run_q  <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				if (i_timed) begin // [R10]
					left_q <= {periods[5:0], 1'b0} + GAP_HALF_EXTRA; // [R18]
					run_q  <= 1'b1;
				end else begin
					o_done <= 1'b1;
				end
			end else if (run_q && i_half) begin
				left_q <= left_q - 7'h01;
				if (left_q == 7'h01) begin
					run_q  <= 1'b0;
					o_done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** src/asx_top.sv ***
/*
 * Automatic multi-byte serial transfer controller with its registers.
 * Assumes buffer RAM outside answers the pointer address combinationally,
 * and the serial mode register outside supplies enable and auto-mode levels.
 */
`timescale 1ns/100ps
`default_nettype none
module asx_top
	import asx_pkg::*;
(
	input  wire logic                    i_ref_clk,   // System clock, 100 MHz.
	input  wire logic                    i_srst,      // Synchronous reset, high.
	input  wire logic [asx_pkg::ADDR_W-1:0] i_addr,   // Register address.
	input  wire logic [7:0]              i_wdata,     // Write data.
	input  wire logic [7:0]              i_wmask,     // Bit write mask, FF for byte.
	input  wire logic                    i_wr,        // Write strobe.
	input  wire logic                    i_rd,        // Read strobe.
	output logic      [7:0]              o_rdata,     // Read data, cycle after strobe.
	input  wire logic                    i_port_en,   // Serial port enable level.
	input  wire logic                    i_auto_mode, // Automatic mode select level.
	input  wire logic                    i_sck,       // Serial clock pin.
	input  wire logic                    i_si,        // Serial input pin.
	output logic                         o_so,        // Serial output pin.
	output logic                         o_si_is_port,// Serial input pin left as port.
	input  wire logic [7:0]              i_buf_rdata, // Buffer byte at pointer.
	output logic [asx_pkg::PTR_W-1:0]    o_buf_addr,  // Buffer pointer.
	output logic [7:0]                   o_buf_wdata, // Received byte.
	output logic                         o_buf_we,    // Received byte strobe.
	output logic                         o_irq        // Interrupt level.
);
	asx_state_t       state_q;
	logic [7:0]       ctrl_q, intv_q;
	logic             busy_q;
	logic [PTR_W-1:0] ptr_q, reload_q;
	logic [1:0]       irq_stat_q, irq_en_q, irq_set;
	logic             sh_start_q, gap_start_q, adv_q;
	logic             sh_half, sh_done, sh_so, gap_done;
	logic [7:0]       sh_rx;
	logic             wr_ctrl, wr_shift, wr_intv, wr_ptr, wr_clr, wr_en;

	// Merges a bit or byte write into the stored value.
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
			input logic [7:0] wm, input logic [7:0] impl);
		merge = ((old & ~wm) | (wd & wm)) & impl;
	endfunction

	// Address decode for write strobes.
	assign wr_ctrl  = i_wr && (i_addr == OFS_CTRL);
	assign wr_shift = i_wr && (i_addr == OFS_SHIFT);
	assign wr_intv  = i_wr && (i_addr == OFS_INTERVAL);
	assign wr_ptr   = i_wr && (i_addr == OFS_POINTER);
	assign wr_clr   = i_wr && (i_addr == OFS_IRQ_CLR);
	assign wr_en    = i_wr && (i_addr == OFS_IRQ_EN);

	// Control register keeps only the two writable mode bits.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ctrl_q <= CTRL_RESET; // [R1]
		end else if (wr_ctrl) begin
			ctrl_q <= merge(ctrl_q, i_wdata, i_wmask, CTRL_WMASK); // [R2] [R8]
		end
	end

	// Interval register; bits 5 and 6 are not stored.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			intv_q <= INTV_RESET; // [R1]
		end else if (wr_intv) begin
			intv_q <= merge(intv_q, i_wdata, i_wmask, INTV_WMASK);
		end
	end

	// Sequencer: load byte, shift it, store reply, wait out the gap.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			state_q     <= ASX_IDLE;
			busy_q      <= 1'b0;
			ptr_q       <= PTR_RESET;
			reload_q    <= PTR_RESET;
			sh_start_q  <= 1'b0;
			gap_start_q <= 1'b0;
			adv_q       <= 1'b0;
			o_buf_we    <= 1'b0;
			o_buf_wdata <= 8'h00;
		end else begin
			sh_start_q  <= 1'b0;
			gap_start_q <= 1'b0;
			adv_q       <= 1'b0;
			o_buf_we    <= 1'b0;
			// The pointer steps one cycle after a store, so the store still sees its own address.
			if (adv_q) begin
				ptr_q <= (ptr_q == PTR_RESET) ? reload_q
					: ptr_q - {{(PTR_W-1){1'b0}}, 1'b1}; // [R5] [R16]
			end
			if (wr_ptr && !busy_q) begin
				ptr_q    <= i_wdata[PTR_W-1:0];
				reload_q <= i_wdata[PTR_W-1:0];
			end
			if (!i_port_en) begin
				state_q <= ASX_IDLE;
				busy_q  <= 1'b0; // [R7]
			end else begin
				unique case (state_q)
					ASX_IDLE: begin
						if (wr_shift && i_auto_mode) begin // [R15]
							busy_q  <= 1'b1; // [R6]
							state_q <= ASX_LOAD;
						end
					end
					ASX_LOAD: begin
						sh_start_q <= 1'b1;
						state_q    <= ASX_SHIFT;
					end
					ASX_SHIFT: begin
						if (sh_done) begin
							if (ctrl_q[CTRL_RX_EN]) begin // [R3]
								o_buf_we    <= 1'b1;
								o_buf_wdata <= sh_rx;
							end
							if (ptr_q != PTR_RESET) begin
								adv_q       <= 1'b1; // [R16]
								gap_start_q <= 1'b1;
								state_q     <= ASX_GAP;
							end else if (ctrl_q[CTRL_REPEAT]) begin // [R5]
								adv_q       <= 1'b1;
								gap_start_q <= 1'b1;
								state_q     <= ASX_GAP;
							end else begin
								busy_q  <= 1'b0; // [R7]
								state_q <= ASX_IDLE;
							end
						end
					end
					ASX_GAP: begin
						if (gap_done) begin
							state_q <= ASX_LOAD;
						end
					end
				endcase
			end
		end
	end

	// Events: sequence end and each finished byte.
	assign irq_set[IRQ_END]  = (state_q == ASX_SHIFT) && sh_done && (ptr_q == PTR_RESET);
	assign irq_set[IRQ_BYTE] = (state_q == ASX_SHIFT) && sh_done;

	// Sticky status; a new event wins over a clear in the same cycle.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			irq_stat_q <= IRQ_RESET;
			irq_en_q   <= IRQ_RESET;
			o_irq      <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~(wr_clr ? i_wdata[1:0] : 2'h0)) | irq_set;
			if (wr_en) begin
				irq_en_q <= (irq_en_q & ~i_wmask[1:0]) | (i_wdata[1:0] & i_wmask[1:0]);
			end
			o_irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// Pin outputs: data low whenever idle, input pin released when not receiving.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_so         <= 1'b0;
			o_si_is_port <= 1'b1;
		end else begin
			o_so         <= busy_q ? sh_so : 1'b0; // [R17]
			o_si_is_port <= !ctrl_q[CTRL_RX_EN] || !i_port_en; // [R4]
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			unique case (i_addr)
				OFS_CTRL:     o_rdata <= ctrl_q | ({7'h00, busy_q} << CTRL_BUSY);
				OFS_INTERVAL: o_rdata <= intv_q;
				OFS_IRQ_STAT: o_rdata <= {6'h00, irq_stat_q};
				OFS_IRQ_EN:   o_rdata <= {6'h00, irq_en_q};
				OFS_POINTER:  o_rdata <= {{(8-PTR_W){1'b0}}, ptr_q};
				default:      o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	assign o_buf_addr = ptr_q;

	asx_shifter u_shifter (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_sck     (i_sck),
		.i_si      (i_si),
		.i_start   (sh_start_q),
		.i_data    (i_buf_rdata),
		.o_half    (sh_half),
		.o_done    (sh_done),
		.o_data    (sh_rx),
		.o_so      (sh_so)
	);

	asx_gap_timer u_gap (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_start   (gap_start_q),
		.i_timed   (intv_q[INTV_CTRL]),
		.i_n       (intv_q[4:0]),
		.i_half    (sh_half),
		.o_done    (gap_done)
	);
endmodule
`default_nettype wire

// *** test/asx_chk.sv ***
/*
 * Port checker for the automatic serial transfer controller.
 * Assumes it is bound into asx_top and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module asx_chk
	import asx_pkg::*;
(
	input wire logic                       i_ref_clk,    // Clock.
	input wire logic                       i_srst,       // Reset.
	input wire logic [asx_pkg::ADDR_W-1:0] i_addr,       // Address.
	input wire logic [7:0]                 i_wdata,      // Write data.
	input wire logic [7:0]                 i_wmask,      // Write mask.
	input wire logic                       i_wr,         // Write strobe.
	input wire logic                       i_rd,         // Read strobe.
	input wire logic [7:0]                 o_rdata,      // Read data.
	input wire logic                       i_port_en,    // Port enable.
	input wire logic                       o_so,         // Serial out.
	input wire logic                       o_si_is_port, // Input left as port.
	input wire logic                       o_buf_we      // Byte store strobe.
);
	logic rx_q; // Shadow of the receive enable bit.
	logic rep_q; // Shadow of the repeat bit.
	// Shadow bits follow masked writes to the control register.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			rx_q <= 1'b0;
			rep_q <= 1'b0;
		end else if (i_wr && i_addr == OFS_CTRL) begin
			rx_q <= i_wmask[7] ? i_wdata[7] : rx_q;
			rep_q <= i_wmask[6] ? i_wdata[6] : rep_q;
		end
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	sequence s_rd(logic [15:0] a);
		i_rd && i_addr == a;
	endsequence
	sequence s_rx_off;
		!rx_q [*2];
	endsequence
	sequence s_off;
		!i_port_en [*3];
	endsequence
	a_rst_quiet: assert property (disable iff (1'b0) i_srst |=>
		o_rdata == 8'h00 && !o_so && o_si_is_port && !o_buf_we) else $error("reset state");
	a_rd_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("stray read data");
	a_ctrl_read: assert property (s_rd(OFS_CTRL) |=>
		o_rdata[7:6] == {rx_q, rep_q} && (o_rdata & 8'h37) == 8'h00) else $error("ctrl read");
	a_shift_zero: assert property (s_rd(OFS_SHIFT) |=> o_rdata == 8'h00)
		else $error("shift read");
	a_intv_gap: assert property (s_rd(OFS_INTERVAL) |=> o_rdata[6:5] == 2'b00)
		else $error("interval bits");
	a_rx_port: assert property (s_rx_off |-> o_si_is_port) else $error("input not port");
	a_rx_nostore: assert property (s_rx_off |-> !o_buf_we) else $error("store with rx off");
	a_so_low: assert property (s_off |-> !o_so) else $error("output not low");
	a_we_single: assert property (o_buf_we |=> !o_buf_we) else $error("double store");
endmodule
bind asx_top asx_chk u_chk (.i_ref_clk, .i_srst, .i_addr, .i_wdata, .i_wmask, .i_wr,
	.i_rd, .o_rdata, .i_port_en, .o_so, .o_si_is_port, .o_buf_we);
`default_nettype wire

// *** test/asx_peer.sv ***
/*
 * Serial peer that clocks the link and feeds the data line.
 * Assumes the bench raises i_run only around automatic sequences.
 */
`timescale 1ns/100ps
`default_nettype none
module asx_peer #(
	parameter realtime HALF = 62.5 // Half serial period.
) (
	input  wire logic i_run, // Clock the link while high.
	input  wire logic i_bit, // Level sent while clocking.
	output logic      o_sck, // Serial clock, idle high.
	output logic      o_si   // Serial data to the block.
);
	// Clock stands high while i_run is low; an unowned data line keeps toggling.
	initial begin
		o_sck = 1'b1;
		o_si = 1'b0;
		#3.3;
		forever begin
			if (i_run) begin
				#(HALF) o_sck = 1'b0;
				o_si = i_bit;
				#(HALF) o_sck = 1'b1;
			end else begin
				#(HALF) o_si = ~o_si;
			end
		end
	end
endmodule
`default_nettype wire

// *** test/asx_top_tb.sv ***
/*
 * Self-checking bench for the automatic serial transfer controller.
 * Assumes asx_peer drives the link and the checker is bound in.
 */
`timescale 1ns/100ps
`default_nettype none
module asx_top_tb;
	import asx_pkg::*;
	logic i_ref_clk, i_srst, i_wr, i_rd, i_port_en, i_auto_mode, i_sck, i_si, o_so;
	logic o_si_is_port, o_buf_we, o_irq, run, bit_lvl;
	logic [15:0] i_addr;
	logic [7:0] i_wdata, i_wmask, o_rdata, i_buf_rdata, o_buf_wdata;
	logic [3:0] o_buf_addr, top_ptr, nxt_ptr;
	int num_errors, checks_done, cyc, g0, g3, gu;
	int tw[$];
	asx_top dut (.i_ref_clk, .i_srst, .i_addr, .i_wdata, .i_wmask, .i_wr, .i_rd, .o_rdata,
		.i_port_en, .i_auto_mode, .i_sck, .i_si, .o_so, .o_si_is_port, .i_buf_rdata,
		.o_buf_addr, .o_buf_wdata, .o_buf_we, .o_irq);
	asx_peer peer (.i_run(run), .i_bit(bit_lvl), .o_sck(i_sck), .o_si(i_si));
	task automatic test_done;
		if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m = 8'hFF);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wmask <= m;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// Starts a sequence and sees the busy bit come up.
	task automatic start(input logic [7:0] ctl, input logic [7:0] itv, input logic [3:0] ptr);
		logic [7:0] d;
		tw.delete();
		top_ptr = ptr;
		nxt_ptr = ptr;
		wr(OFS_INTERVAL, itv);
		wr(OFS_POINTER, {4'h0, ptr});
		wr(OFS_CTRL, ctl);
		run <= 1'b1;
		wr(OFS_SHIFT, 8'h3C);
		rd(OFS_CTRL, d);
		chk(d, ctl | 8'h08);
	endtask
	// One-shot sequence polled to its end; returns the first byte spacing.
	task automatic seq(input logic [7:0] ctl, itv, input logic [3:0] ptr, input int nb,
		output int gap);
		logic [7:0] d;
		start(ctl, itv, ptr);
		d = 8'h08;
		for (int k = 0; k < 600 && d[3] !== 1'b0; k++) rd(OFS_CTRL, d);
		chk(d, ctl);
		run <= 1'b0;
		chk(8'(tw.size()), 8'(nb));
		gap = tw.size() > 1 ? tw[1] - tw[0] : 0;
	endtask
	task automatic t_regs;
		logic [7:0] d;
		logic [15:0] ra [5];
		ra = '{OFS_CTRL, OFS_INTERVAL, OFS_IRQ_EN, OFS_POINTER, 16'hFF70};
		foreach (ra[i]) begin
			rd(ra[i], d);
			chk(d, 8'h00);
		end
		wr(OFS_CTRL, 8'hFF);
		rd(OFS_CTRL, d);
		chk(d, 8'hC0);
		wr(OFS_CTRL, 8'h00, 8'h80);
		rd(OFS_CTRL, d);
		chk(d, 8'h40);
		wr(OFS_INTERVAL, 8'h9F);
		rd(OFS_INTERVAL, d);
		chk(d, 8'h9F);
	endtask
	task automatic t_gaps;
		wr(OFS_IRQ_EN, 8'h01);
		seq(8'h80, 8'h80, 4'h2, 3, g0);
		chk(o_irq, 1'b1);
		wr(OFS_IRQ_CLR, 8'h01);
		repeat (2) @(posedge i_ref_clk);
		chk(o_irq, 1'b0);
		seq(8'h80, 8'h83, 4'h2, 3, g3);
		seq(8'h80, 8'h00, 4'h2, 3, gu);
		chk(8'(g3 - g0 >= 23 && g3 - g0 <= 27), 8'h01);
		chk(8'(gu < g0), 8'h01);
	endtask
	task automatic t_rx_off;
		logic [7:0] d;
		wr(OFS_IRQ_EN, 8'h00);
		seq(8'h00, 8'h00, 4'h1, 0, g0);
		chk(o_si_is_port, 1'b1);
		chk(o_irq, 1'b0);
		rd(OFS_IRQ_STAT, d);
		chk(d & 8'h01, 8'h01);
		i_auto_mode <= 1'b0;
		wr(OFS_SHIFT, 8'h00);
		rd(OFS_CTRL, d);
		chk(d, 8'h00);
		i_auto_mode <= 1'b1;
	endtask
	task automatic t_repeat;
		logic [7:0] d;
		start(8'hC0, 8'h00, 4'h1);
		for (int k = 0; k < 2000 && tw.size() < 3; k++) @(posedge i_ref_clk);
		rd(OFS_CTRL, d);
		chk(d, 8'hC8);
		chk(o_si_is_port, 1'b0);
		i_port_en <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		rd(OFS_CTRL, d);
		chk(d, 8'hC0);
		chk(o_so, 1'b0);
		i_port_en <= 1'b1;
		run <= 1'b0;
	endtask
	// Resets in mid-sequence and sees control and interval read zero and the input pin back as port.
	task automatic t_reset;
		logic [7:0] d;
		start(8'h80, 8'h85, 4'h3);
		repeat (150) @(posedge i_ref_clk);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		run <= 1'b0;
		rd(OFS_CTRL, d);
		chk(d, 8'h00);
		rd(OFS_INTERVAL, d);
		chk(d, 8'h00);
		chk(o_si_is_port, 1'b1);
	endtask
	// Logs stored bytes and cuts a hang short.
	always @(posedge i_ref_clk) begin
		cyc++;
		if (o_buf_we === 1'b1) begin
			tw.push_back(cyc);
			chk(o_buf_wdata, 8'hFF);
			chk({4'h0, o_buf_addr}, {4'h0, nxt_ptr});
			nxt_ptr = (nxt_ptr == 4'h0) ? top_ptr : nxt_ptr - 4'h1;
		end
		if (cyc == 60000) begin
			num_errors++;
			$display("mismatch at %0t: timeout", $time);
			test_done();
		end
	end
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		{i_srst, i_wr, i_rd, i_port_en, i_auto_mode, run, bit_lvl} = 7'b1001101;
		{i_addr, i_wdata, i_wmask, i_buf_rdata} = {16'h0000, 8'h00, 8'hFF, 8'h5A};
		repeat (6) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		t_regs();
		t_gaps();
		t_rx_off();
		t_repeat();
		t_reset();
		test_done();
	end
endmodule
`default_nettype wire
